/* File: include/sep_consts.vh */
// Purpose: constants for the two-wire serial eeprom target
// Assumes: 25 MHz system clock
// Notes: times in ns, counts derived from the clock period
`ifndef SEP_CONSTS_VH
`define SEP_CONSTS_VH
`define SEP_CLK_PERIOD_NS 40
`define SEP_PROG_TIME_NS 5000000
`define SEP_PROG_CYCLES (`SEP_PROG_TIME_NS / `SEP_CLK_PERIOD_NS)
`define SEP_TYPE_ARRAY 4'ha
`define SEP_TYPE_SERIAL 4'hb
`define SEP_SERIAL_TAG 2'h2
`define SEP_PAGE_BITS 4
`define SEP_SERIAL_BYTES 16
`define SEP_ERASED_BYTE 8'hff
`endif

/* File: design/sep_sync.v */
// Purpose: two flip-flop synchroniser for one pin
// Assumes: input is asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module sep_sync (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_async,
	output reg o_sync
);
	reg meta;

	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			meta <= 1'b1;
			o_sync <= 1'b1;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule

/* File: design/sep_eeprom_target.v */
// Purpose: two-wire bus target of a small serial eeprom with serial number region
// Assumes: SCL and SDA sampled by I_REF_CLK; bus wire resolved outside
// Notes: array held in flip-flops; serial number is a parameter
//
// How it works
// - 9 or 10 bit word address selects byte
// - data acked; stop starts timed programming
// - busy programming, bus inputs ignored
// - page write up to 16 bytes, same row
// - further bytes acked; stop starts programming
// - only low four address bits wrap in page
// - busy: write address not acked, polling
// - protect pin high blocks array writes
// - protect pin sampled at the starting stop
// - protected writes acked, no programming, ready
// - one pointer for array and serial region
// - pointer keeps last address plus one
// - current read acks then sends pointer byte
// - read ends at controller nack, ninth clock
// - read address ignores word high bits
// - acked reads increment, wrap whole array
// - serial reads need tag 10, else read ff
// - serial read wraps within sixteen bytes
// - type 1010 array, 1011 serial region
// - strap bits compared (high only at 10 bit), mismatch not acked
`timescale 1ns/1ps
`include "sep_consts.vh"
module sep_eeprom_target #(
	parameter ADDR_BITS = 9,
	parameter PROG_CYCLES = `SEP_PROG_CYCLES,
	parameter [127:0] SERIAL_VALUE = 128'h0123456789abcdeffedcba9876543210
) (
	input wire I_REF_CLK,
	input wire I_RESET_N,
	input wire I_SCL,
	input wire I_SDA,
	output reg O_SDA,
	output reg O_SDA_OE,
	input wire I_WRITE_PROTECT,
	input wire I_STRAP_ADDRESS_BIT_HIGH,
	input wire I_STRAP_ADDRESS_BIT_LOW,
	output wire O_BUSY
);
	localparam DEPTH = 1 << ADDR_BITS;
	localparam HI_BITS = ADDR_BITS - 8;
	localparam PB = `SEP_PAGE_BITS;
	localparam PAGE = 1 << PB;
	localparam [31:0] PROG_MAX = (PROG_CYCLES < 1) ? 32'd1 :
		((PROG_CYCLES > `SEP_PROG_CYCLES) ? `SEP_PROG_CYCLES : PROG_CYCLES);

	localparam ST_IDLE = 3'd0;
	localparam ST_DEV = 3'd1;
	localparam ST_WORD = 3'd2;
	localparam ST_DATA = 3'd3;
	localparam ST_READ = 3'd4;
	localparam ST_MACK = 3'd5;
	localparam ST_SKIP = 3'd6;

	// ==========================================================
	// pin sampling
	// ==========================================================
	wire scl_s;
	wire sda_s;
	wire wp_s;
	wire strap_hi;
	wire strap_lo;

	sep_sync u_scl (.i_clk(I_REF_CLK), .i_reset_n(I_RESET_N), .i_async(I_SCL), .o_sync(scl_s));
	sep_sync u_sda (.i_clk(I_REF_CLK), .i_reset_n(I_RESET_N), .i_async(I_SDA), .o_sync(sda_s));
	sep_sync u_wp (.i_clk(I_REF_CLK), .i_reset_n(I_RESET_N), .i_async(I_WRITE_PROTECT), .o_sync(wp_s));
	sep_sync u_sh (.i_clk(I_REF_CLK), .i_reset_n(I_RESET_N), .i_async(I_STRAP_ADDRESS_BIT_HIGH),
		.o_sync(strap_hi));
	sep_sync u_sl (.i_clk(I_REF_CLK), .i_reset_n(I_RESET_N), .i_async(I_STRAP_ADDRESS_BIT_LOW),
		.o_sync(strap_lo));

	reg scl_d;
	reg sda_d;
	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start_c = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_c = scl_s & scl_d & ~sda_d & sda_s;

	// edge history, idle level of both wires is high
	always @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	// ==========================================================
	// storage and state
	// ==========================================================
	reg [7:0] mem [0:DEPTH-1];
	reg [7:0] page_buf [0:PAGE-1];
	reg [PAGE-1:0] page_mask;
	reg [ADDR_BITS-1:0] page_base;
	reg [ADDR_BITS-1:0] ptr;
	reg ptr_serial;
	reg serial_tag_ok;
	reg [2:0] state;
	reg [3:0] bitcnt;
	reg [7:0] shreg;
	reg is_serial;
	reg [HI_BITS-1:0] dev_hi;
	reg wr_pending;
	reg busy;
	reg [31:0] prog_cnt;
	reg ack_phase;
	integer k;

	assign O_BUSY = busy;

	// ==========================================================
	// device address decode
	// ==========================================================
	wire [3:0] dev_type = shreg[7:4];
	wire [1:0] ser_zero_bits = (ADDR_BITS == 9) ? {1'b0, shreg[1]} : shreg[2:1];
	wire [HI_BITS-1:0] hi_field = shreg[HI_BITS:1];
	wire type_ser = (dev_type == `SEP_TYPE_SERIAL);
	reg strap_ok;
	reg dev_match;

	always @* begin
		if (ADDR_BITS == 9)
			strap_ok = (shreg[3] == strap_hi) && (shreg[2] == strap_lo);
		else
			strap_ok = (shreg[3] == strap_hi);
	end

	always @* begin
		dev_match = 1'b0;
		if (strap_ok) begin
			case (dev_type)
				`SEP_TYPE_ARRAY: begin
					dev_match = 1'b1;
				end
				`SEP_TYPE_SERIAL: begin
					// serial region takes no high word bits on writes
					dev_match = shreg[0] | (ser_zero_bits == 2'b00);
				end
				default: begin
					dev_match = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// read data source
	// ==========================================================
	wire [3:0] ser_idx = ptr[3:0];
	reg [7:0] ser_byte;
	reg [7:0] rd_byte;
	integer j;

	always @* begin
		ser_byte = 8'h00;
		for (j = 0; j < `SEP_SERIAL_BYTES; j = j + 1) begin
			if (ser_idx == j[3:0])
				ser_byte = SERIAL_VALUE[127 - 8 * j -: 8];
		end
	end

	always @* begin
		case ({ptr_serial, serial_tag_ok})
			2'b11: rd_byte = ser_byte;
			2'b10: rd_byte = `SEP_ERASED_BYTE;
			default: rd_byte = mem[ptr];
		endcase
	end

	// ==========================================================
	// write cycle timer and page commit
	// ==========================================================
	reg [31:0] next_prog_cnt;
	wire prog_done = (prog_cnt >= PROG_MAX - 32'd1);

	always @* begin
		next_prog_cnt = prog_cnt;
		if (!busy || prog_done)
			next_prog_cnt = 32'h0;
		else
			next_prog_cnt = prog_cnt + 32'd1;
	end

	always @(posedge I_REF_CLK) begin
		if (!I_RESET_N)
			prog_cnt <= 32'h0;
		else
			prog_cnt <= next_prog_cnt;
	end

	// cells change only when the timed cycle ends
	always @(posedge I_REF_CLK) begin
		if (I_RESET_N && busy && prog_done) begin
			for (k = 0; k < PAGE; k = k + 1) begin
				if (page_mask[k])
					mem[{page_base[ADDR_BITS-1:PB], k[PB-1:0]}] <= page_buf[k];
			end
		end
	end

	// ==========================================================
	// protocol engine
	// ==========================================================
	always @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			state <= ST_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			is_serial <= 1'b0;
			dev_hi <= {HI_BITS{1'b0}};
			ptr <= {ADDR_BITS{1'b0}};
			ptr_serial <= 1'b0;
			serial_tag_ok <= 1'b0;
			page_mask <= {PAGE{1'b0}};
			page_base <= {ADDR_BITS{1'b0}};
			wr_pending <= 1'b0;
			busy <= 1'b0;
			ack_phase <= 1'b0;
			O_SDA <= 1'b1;
			O_SDA_OE <= 1'b0;
		end else begin
			if (busy) begin
				// bus ignored while the cell timer runs
				O_SDA_OE <= 1'b0;
				state <= ST_IDLE;
				if (prog_done) begin
					busy <= 1'b0;
					page_mask <= {PAGE{1'b0}};
				end
			end else if (stop_c) begin
				state <= ST_IDLE;
				O_SDA_OE <= 1'b0;
				wr_pending <= 1'b0;
				if (wr_pending && page_mask != {PAGE{1'b0}}) begin
					if (wp_s) begin
						page_mask <= {PAGE{1'b0}};
					end else begin
						busy <= 1'b1;
					end
				end
			end else if (start_c) begin
				state <= ST_DEV;
				bitcnt <= 4'h0;
				ack_phase <= 1'b0;
				O_SDA_OE <= 1'b0;
				wr_pending <= 1'b0;
				page_mask <= {PAGE{1'b0}};
			end else if (state != ST_IDLE && state != ST_SKIP) begin
				if (scl_rise && !ack_phase && state != ST_READ) begin
					shreg <= {shreg[6:0], sda_s};
					bitcnt <= bitcnt + 4'h1;
				end
				if (scl_rise && state == ST_READ && ack_phase) begin
					// controller answer in ninth clock
					if (sda_s) begin
						state <= ST_SKIP;
					end else begin
						state <= ST_MACK;
					end
				end
				if (scl_fall) begin
					if (ack_phase) begin
						ack_phase <= 1'b0;
						O_SDA_OE <= 1'b0;
						bitcnt <= 4'h0;
						if (state == ST_READ || state == ST_MACK) begin
							state <= ST_READ;
							O_SDA <= rd_byte[7];
							O_SDA_OE <= 1'b1;
							shreg <= {rd_byte[6:0], 1'b0};
							bitcnt <= 4'h1;
							if (ptr_serial)
								ptr[3:0] <= ptr[3:0] + 4'h1;
							else
								ptr <= ptr + {{(ADDR_BITS-1){1'b0}}, 1'b1};
						end
					end else if (state == ST_READ) begin
						if (bitcnt == 4'd8) begin
							ack_phase <= 1'b1;
							O_SDA_OE <= 1'b0;
						end else begin
							O_SDA <= shreg[7];
							shreg <= {shreg[6:0], 1'b0};
							bitcnt <= bitcnt + 4'h1;
						end
					end else if (bitcnt == 4'd8) begin
						ack_phase <= 1'b1;
						O_SDA <= 1'b0;
						O_SDA_OE <= 1'b1;
						case (state)
							ST_DEV: begin
								if (dev_match) begin
									is_serial <= type_ser;
									dev_hi <= hi_field;
									if (shreg[0]) begin
										state <= ST_READ;
										if (type_ser != ptr_serial)
											ptr_serial <= type_ser;
									end else begin
										state <= ST_WORD;
									end
								end else begin
									O_SDA_OE <= 1'b0;
									ack_phase <= 1'b0;
									state <= ST_SKIP;
								end
							end
							ST_WORD: begin
								ptr <= {dev_hi, shreg};
								ptr_serial <= is_serial;
								serial_tag_ok <= (shreg[7:6] == `SEP_SERIAL_TAG);
								page_base <= {dev_hi, shreg[7:PB], {PB{1'b0}}};
								state <= is_serial ? ST_SKIP : ST_DATA;
								if (is_serial)
									ack_phase <= 1'b1;
							end
							ST_DATA: begin
								page_buf[ptr[PB-1:0]] <= shreg;
								page_mask[ptr[PB-1:0]] <= 1'b1;
								wr_pending <= 1'b1;
								ptr[PB-1:0] <= ptr[PB-1:0] + 4'h1;
							end
							default: begin
								state <= ST_SKIP;
							end
						endcase
					end
				end
			end else if (state == ST_SKIP && ack_phase && scl_fall) begin
				ack_phase <= 1'b0;
				O_SDA_OE <= 1'b0;
			end
		end
	end
endmodule

/* File: tb/sep_host_model.sv */
// Purpose: two-wire controller model for the eeprom target
// Assumes: data wire pulled up, released when not driven low
// Notes: 16 reference clocks per bus bit
`timescale 1ns/1ps
module sep_host_model (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl = 1,
	output logic o_sda_low = 0
);
	logic [7:0] res;
	event got;
	// ====================
	// bus phases
	task automatic w(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// start when st, stop otherwise
	task automatic cond(input logic st);
		w(4);
		o_sda_low = !st;
		w(4);
		o_scl = 1;
		w(8);
		o_sda_low = st;
		w(8);
		o_scl = !st;
	endtask
	task automatic xfer(input logic [7:0] d, input logic rd, last);
		logic r;
		for (int i = 8; i >= 0; i--) begin
			w(4);
			o_sda_low = i ? !(rd | d[i - 1]) : rd & !last;
			w(4);
			o_scl = 1;
			w(8);
			r = i_sda;
			o_scl = 0;
			res = i ? {res[6:0], r} : rd ? res : {7'h0, !r};
		end
		-> got;
	endtask
endmodule

/* File: tb/sep_eeprom_target_props.sv */
// Purpose: port checks of the eeprom target
// Assumes: one clock domain
// Notes: bound to the top module
`timescale 1ns/1ps
module sep_eeprom_target_props #(parameter PROG_CYCLES = 400) (
	input wire I_REF_CLK,
	input wire I_RESET_N,
	input wire I_SCL,
	input wire I_SDA,
	input wire O_SDA,
	input wire O_SDA_OE,
	input wire I_WRITE_PROTECT,
	input wire O_BUSY
);
	logic scl_q, sda_q, wp_stop;
	logic [3:0] since;
	int cnt;
	default clocking @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RESET_N);
	sequence s_prog;
		O_BUSY [*8];
	endsequence
	// ====================
	// stop tracker
	always @(posedge I_REF_CLK) begin
		scl_q <= I_SCL;
		sda_q <= I_SDA;
		cnt <= O_BUSY ? cnt + 1 : 0;
		if (I_SCL && scl_q && I_SDA && !sda_q) begin
			since <= 4'h0;
			wp_stop <= I_WRITE_PROTECT;
		end else if (!I_RESET_N || since != 4'hf)
			since <= I_RESET_N ? since + 4'h1 : 4'hf;
	end
	a_reset_quiet: assert property (disable iff (1'b0) !I_RESET_N |=> !O_SDA_OE && !O_BUSY)
		else $error("bus active after reset");
	a_busy_silent: assert property (O_BUSY |-> !O_SDA_OE)
		else $error("answered while programming");
	a_ack_scl_low: assert property ($rose(O_SDA_OE) |-> !I_SCL)
		else $error("drive began with clock high");
	a_out_steady: assert property (I_SCL [*4] |-> $stable(O_SDA) && $stable(O_SDA_OE))
		else $error("data moved with clock high");
	a_prog_at_stop: assert property ($rose(O_BUSY) |-> since < 4'ha)
		else $error("programming without stop");
	a_wp_blocks: assert property ($rose(O_BUSY) |-> !wp_stop)
		else $error("programming while protected");
	a_prog_length: assert property ($fell(O_BUSY) |-> cnt == PROG_CYCLES)
		else $error("programming length wrong");
	a_busy_holds: assert property ($rose(O_BUSY) |-> s_prog)
		else $error("programming cut short");
endmodule
bind sep_eeprom_target sep_eeprom_target_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.I_REF_CLK(I_REF_CLK),
	.I_RESET_N(I_RESET_N), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE),
	.I_WRITE_PROTECT(I_WRITE_PROTECT), .O_BUSY(O_BUSY));

/* File: tb/sep_eeprom_target_test.sv */
// Purpose: self-checking bench of the eeprom target
// Assumes: data wire pulled up, straps random
// Notes: short programming count, shadow array for reads
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((e) !== (s)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", nm, e, s); end end
module sep_eeprom_target_test;
	localparam int PC = 400;
	localparam logic [127:0] SN = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
	logic clk = 0, rst_n = 0, wp = 0, sda_w, scl, low, d_sda, d_oe, busy, s_hi = 0, s_lo = 0;
	logic [7:0] mem [512], exp_q [$], d, e;
	int seed = 48688, checked = 0, n_mismatch = 0, cyc = 0;
	always #20 clk = !clk;
	assign sda_w = !low && (d_oe ? d_sda : 1'b1);
	sep_eeprom_target #(.ADDR_BITS(9), .PROG_CYCLES(PC), .SERIAL_VALUE(SN)) uut (.I_REF_CLK(clk),
		.I_RESET_N(rst_n), .I_SCL(scl), .I_SDA(sda_w), .O_SDA(d_sda), .O_SDA_OE(d_oe), .I_WRITE_PROTECT(wp),
		.I_STRAP_ADDRESS_BIT_HIGH(s_hi), .I_STRAP_ADDRESS_BIT_LOW(s_lo), .O_BUSY(busy));
	sep_host_model m (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(low));
	// ====================
	// result watcher
	always @(m.got) begin
		e = exp_q.pop_front();
		`CHK("bus byte", e, m.res)
	end
	always @(posedge clk)
		if (++cyc == 60000) begin
			n_mismatch++;
			summarize();
		end
	task automatic summarize();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic tx(input logic [7:0] v, ex, input logic rd = 0, last = 0);
		exp_q.push_back(ex);
		m.xfer(v, rd, last);
	endtask
	task automatic wr(input logic [8:0] a, input int n, input logic prot);
		wp = prot;
		m.cond(1);
		tx({4'ha, s_hi, s_lo, a[8], 1'b0}, 8'h1);
		tx(a[7:0], 8'h1);
		repeat (n) begin
			d = 8'($random(seed));
			tx(d, 8'h1);
			if (!prot)
				mem[a] = d;
			a[3:0] += 4'h1;
		end
		m.cond(0);
		wp = !prot;
		m.cond(1);
		tx({4'ha, s_hi, s_lo, 2'b00}, {7'h0, prot});
		m.cond(0);
		for (int k = 0; k < 2 * PC && busy !== 1'b0; k++)
			@(posedge clk);
		m.cond(1);
		tx({4'ha, s_hi, s_lo, 2'b00}, 8'h1);
		m.cond(0);
	endtask
	task automatic rd(input logic [8:0] a, input int n, input logic sn, dummy);
		logic [3:0] dv;
		dv = sn ? 4'hb : 4'ha;
		if (dummy) begin
			m.cond(1);
			tx({dv, s_hi, s_lo, a[8] & !sn, 1'b0}, 8'h1);
			tx(a[7:0], 8'h1);
		end
		m.cond(1);
		tx({dv, s_hi, s_lo, 1'($random(seed)), 1'b1}, 8'h1);
		for (int i = 1; i <= n; i++) begin
			tx(8'h0, !sn ? mem[a] : a[7:6] == 2'b10 ? SN[127 - 8 * a[3:0] -: 8] : 8'hff, 1, i == n);
			a = sn ? {a[8:4], a[3:0] + 4'h1} : a + 9'h1;
		end
		m.cond(0);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		#1 rst_n = 1;
		{s_hi, s_lo} = 2'($random(seed));
		wr(9'h1fe, 4, 0);
		wr(9'h000, 4, 0);
		wr(9'h001, 2, 1);
		rd(9'h1f0, 2, 0, 1);
		rd(9'h1fe, 5, 0, 1);
		rd(9'h003, 1, 0, 0);
		rd(9'h080, 17, 1, 1);
		rd(9'h040, 1, 1, 1);
		for (int i = 0; i < 2; i++) begin
			m.cond(1);
			tx(i ? {4'hc, s_hi, s_lo, 2'b00} : {4'ha, !s_hi, s_lo, 2'b00}, 8'h0);
		end
		m.cond(0);
		summarize();
	end
endmodule
